// File: common/scp_pkg.sv
package scp_pkg;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int DEB_TIME_MS = 5;
	localparam int LOCK_TIME_MS = 5;
	localparam int ADDR_TIME_MS = 5;
	// Least times, exact at this rate, so no rounding is lost
	localparam int DEB_CYC = DEB_TIME_MS * CYC_PER_MS;
	localparam int LOCK_CYC = LOCK_TIME_MS * CYC_PER_MS;
	localparam int ADDR_CYC = ADDR_TIME_MS * CYC_PER_MS;

	// ****************************************************************
	// Pin positions in the synchroniser vector
	// ****************************************************************
	localparam int PIN_EN = 0;
	localparam int PIN_INH = 1;
	localparam int PIN_SB0 = 2;
	localparam int PIN_SB1 = 3;
	localparam int PIN_SCL = 4;
	localparam int PIN_SDA = 6;
	localparam int PIN_NUM = 8;
	localparam int PORT_NUM = 2;
	localparam logic [PIN_NUM-1:0] PIN_IDLE = 8'hff;

	// ****************************************************************
	// Bus address and commands
	// ****************************************************************
	localparam logic [6:0] ADDR_BASE = 7'h20;
	localparam logic [7:0] CMD_HOT = 8'h21;
	localparam logic [7:0] CMD_BOTH = 8'h92;
	localparam logic [7:0] FILL_BYTE = 8'hff;
	localparam logic [3:0] BIT_FULL = 4'h8;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [1:0] IDX_FIRST = 2'h0;
	localparam logic [1:0] IDX_SECOND = 2'h1;
	localparam logic [1:0] IDX_TOP = 2'h3;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_AACK = 3'h3,
		ST_WDAT = 3'h2,
		ST_WACK = 3'h6,
		ST_RDAT = 3'h7,
		ST_RACK = 3'h5
	} scp_i2c_st_t;

	typedef struct packed {
		logic [7:0] hot;
		logic [7:0] a;
		logic [7:0] b;
	} scp_temp_t;

	typedef struct packed {
		logic prio;
		logic main_on;
		logic aux_on;
	} scp_sw_t;

	typedef struct packed {
		logic main_on;
		logic aux_on;
	} scp_rail_t;
endpackage : scp_pkg

// File: verilog/scp_debounce.sv
`timescale 1ns/1ps
module scp_debounce #(
	parameter int CYC = scp_pkg::DEB_CYC,
	parameter logic INIT = 1'b1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Synchronised level in, filtered level out
	input wire logic i_raw,
	output logic o_level,
	output logic o_busy
);
	import scp_pkg::*;

	localparam int CW = $clog2(CYC + 1);
	localparam logic [CW-1:0] CNT_END = CW'(CYC - 1);

	// ****************************************************************
	// Parameter check
	// ****************************************************************
	if (CYC < 1) begin : g_bad_cyc
		$error("scp_debounce: CYC must be at least one");
	end

	// ****************************************************************
	// Filter
	// ****************************************************************
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic level_reg;
	wire differ = i_raw != level_reg;
	wire done = cnt_reg == CNT_END;

	// Count consecutive cycles that disagree, restart on agreement
	assign cnt_next = (!differ || done) ? '0 : cnt_reg + 1'b1;

	// Level flips only after CYC disagreeing cycles in a row
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cnt_reg <= '0;
			level_reg <= INIT;
		end else begin
			cnt_reg <= cnt_next;
			if (differ && done) begin
				level_reg <= i_raw;
			end
		end
	end

	assign o_level = level_reg;
	assign o_busy = differ;
endmodule : scp_debounce

// File: verilog/scp_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Enable low with inhibit high turns all rails on, both low gives aux only, enable high off.
// - Enable and inhibit are debounced before they can change the rails.
// - After a turn-on, further turn-ons wait out a lockout interval; turn-offs are immediate.
// - Address is 20h plus the inverted slot bits: 21h, 22h, 23h for bit0, bit1, both low.
// - Both slot bits are debounced before they form the address.
// - The address is caught once after reset and never changes until the next reset.
// - Primary and redundant bus ports answer at the same address with the same commands.
// - The fault pin follows the hold pin while starting and pulls low on an output fault.
// - The hold pin is pulled low while starting and released once control is accepted.
// - Command 21h reads back the hotter of the two sensors, with no clamping.
// - Command 92h reads back both sensors, first sensor a, then sensor b.
// - The pins own the rails while software priority is 0; it is an input with no reset value.
module scp_top #(
	parameter int DEB_CYC = scp_pkg::DEB_CYC,
	parameter int LOCK_CYC = scp_pkg::LOCK_CYC,
	parameter int ADDR_CYC = scp_pkg::ADDR_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Control and slot pins, asynchronous
	input wire logic i_enable_n,
	input wire logic i_inhibit_n,
	input wire logic i_slot_bit0_n,
	input wire logic i_slot_bit1_n,
	// Monitors, sensors and software control, same clock
	input wire logic i_supply_ok,
	input wire logic i_out_fault,
	input wire logic [7:0] i_temp_a,
	input wire logic [7:0] i_temp_b,
	input wire scp_pkg::scp_sw_t i_sw,
	// Management bus ports, index 0 primary, 1 redundant
	input wire logic [1:0] i_scl,
	input wire logic [1:0] i_sda,
	output logic [1:0] o_sda,
	output logic [1:0] o_sda_oe,
	// Open-drain status pins
	output logic o_startup_hold_n,
	output logic o_startup_hold_n_oe,
	output logic o_fail_n,
	output logic o_fail_n_oe,
	// Rail enables and state
	output scp_pkg::scp_rail_t o_rail,
	output logic [6:0] o_addr,
	output logic o_ready
);
	import scp_pkg::*;

	localparam int LW = $clog2(LOCK_CYC + 1);
	localparam int AW = $clog2(ADDR_CYC + 1);
	localparam logic [LW-1:0] LOCK_END = LW'(LOCK_CYC - 1);
	localparam logic [AW-1:0] ADDR_END = AW'(ADDR_CYC);

	// ****************************************************************
	// Parameter check
	// ****************************************************************
	if (LOCK_CYC < 1 || ADDR_CYC < DEB_CYC + 2 || DEB_CYC < 1) begin : g_bad_par
		$error("scp_top: counts must be positive and the address wait must cover the filter");
	end

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic scp_rail_t decode_rails(input logic en_n, input logic inh_n);
		scp_rail_t r;
		r.main_on = !en_n && inh_n;
		r.aux_on = !en_n;
		return r;
	endfunction : decode_rails

	function automatic logic [7:0] resp_byte(input logic [7:0] cmd, input logic [1:0] idx,
			input scp_temp_t t);
		if (cmd == CMD_HOT && idx == IDX_FIRST) begin
			return t.hot;
		end
		if (cmd == CMD_BOTH && idx == IDX_FIRST) begin
			return t.a;
		end
		if (cmd == CMD_BOTH && idx == IDX_SECOND) begin
			return t.b;
		end
		return FILL_BYTE;
	endfunction : resp_byte

	// ****************************************************************
	// Synchronisers
	// ****************************************************************
	logic [PIN_NUM-1:0] sync1_reg;
	logic [PIN_NUM-1:0] sync2_reg;
	logic [3:0] bus_dly_reg;
	wire [PIN_NUM-1:0] pins = {i_sda, i_scl, i_slot_bit1_n, i_slot_bit0_n, i_inhibit_n,
		i_enable_n};

	// Two stages per pin; the third stage on the bus lines only finds edges
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sync1_reg <= PIN_IDLE;
			sync2_reg <= PIN_IDLE;
			bus_dly_reg <= '1;
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
			bus_dly_reg <= sync2_reg[PIN_NUM-1:PIN_SCL];
		end
	end

	// ****************************************************************
	// Debounce of control and slot pins
	// ****************************************************************
	logic [3:0] filt;
	logic [3:0] filt_busy;

	// One filter per pin, all idle high like the pull-ups
	for (genvar g = 0; g < 4; g++) begin : g_deb
		scp_debounce #(
			.CYC(DEB_CYC),
			.INIT(1'b1)
		) u_deb (
			.i_clk(i_clk),
			.i_rst_n(i_rst_n),
			.i_raw(sync2_reg[g]),
			.o_level(filt[g]),
			.o_busy(filt_busy[g])
		);
	end

	// ****************************************************************
	// Address capture and start-up
	// ****************************************************************
	logic [AW-1:0] up_cnt_reg;
	logic [6:0] addr_reg;
	logic addr_ok_reg;
	logic ready_reg;
	wire up_done = up_cnt_reg == ADDR_END;
	wire slots_quiet = !filt_busy[PIN_SB0] && !filt_busy[PIN_SB1];
	wire capture = up_done && slots_quiet && !addr_ok_reg;
	wire [6:0] addr_w = ADDR_BASE | {5'h00, !filt[PIN_SB1], !filt[PIN_SB0]};

	// Wait past one filter time so a pin held low has settled, then latch once
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			up_cnt_reg <= '0;
			addr_reg <= ADDR_BASE;
			addr_ok_reg <= 1'b0;
		end else begin
			if (!up_done) begin
				up_cnt_reg <= up_cnt_reg + 1'b1;
			end
			if (capture) begin
				addr_reg <= addr_w;
				addr_ok_reg <= 1'b1;
			end
		end
	end

	// Ready once the address is held and the supply reports good; stays set
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ready_reg <= 1'b0;
		end else if (addr_ok_reg && i_supply_ok) begin
			ready_reg <= 1'b1;
		end
	end

	// ****************************************************************
	// Rail control with lockout
	// ****************************************************************
	scp_rail_t rail_reg;
	scp_rail_t pin_req;
	scp_rail_t sw_req;
	scp_rail_t req;
	scp_rail_t rail_next;
	logic [LW-1:0] lock_cnt_reg;
	wire locked = lock_cnt_reg != '0;
	wire turn_on;

	// Source select, pins first unless software priority is set
	assign pin_req = decode_rails(filt[PIN_EN], filt[PIN_INH]);
	assign sw_req = '{main_on: i_sw.main_on, aux_on: i_sw.aux_on};
	assign req = !ready_reg ? '0 : (i_sw.prio ? sw_req : pin_req);
	assign turn_on = (req.main_on && !rail_reg.main_on) || (req.aux_on && !rail_reg.aux_on);
	// While locked only turn-offs pass, so no restart hits a charging load
	assign rail_next = (turn_on && locked) ? (rail_reg & req) : req;

	// Rails and lockout counter
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rail_reg <= '0;
			lock_cnt_reg <= '0;
		end else begin
			rail_reg <= rail_next;
			if (turn_on && !locked) begin
				lock_cnt_reg <= LOCK_END;
			end else if (locked) begin
				lock_cnt_reg <= lock_cnt_reg - 1'b1;
			end
		end
	end

	// ****************************************************************
	// Status pins
	// ****************************************************************
	logic hold_oe_reg;
	logic fail_oe_reg;
	logic lo_reg;

	// Enables are high while pulling low; the driven level is always low
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			hold_oe_reg <= 1'b1;
			fail_oe_reg <= 1'b1;
			lo_reg <= 1'b0;
		end else begin
			hold_oe_reg <= !ready_reg;
			fail_oe_reg <= !ready_reg || i_out_fault;
			lo_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// Sensor readings
	// ****************************************************************
	scp_temp_t temp_reg;
	wire a_hotter = $signed(i_temp_a) > $signed(i_temp_b);

	// Snapshot each cycle; the hotter value is passed unclamped
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			temp_reg <= '0;
		end else begin
			temp_reg.hot <= a_hotter ? i_temp_a : i_temp_b;
			temp_reg.a <= i_temp_a;
			temp_reg.b <= i_temp_b;
		end
	end

	// ****************************************************************
	// Management bus ports
	// ****************************************************************
	logic [1:0] sda_oe_reg;

	// Same logic, same address and same command set on both ports
	for (genvar p = 0; p < PORT_NUM; p++) begin : g_port
		scp_i2c_st_t st_reg;
		logic [7:0] sh_reg;
		logic [7:0] tx_reg;
		logic [7:0] cmd_reg;
		logic [3:0] cnt_reg;
		logic [1:0] idx_reg;
		logic rw_reg;
		logic nack_reg;
		wire scl = sync2_reg[PIN_SCL+p];
		wire sda = sync2_reg[PIN_SDA+p];
		wire scl_d = bus_dly_reg[p];
		wire sda_d = bus_dly_reg[PORT_NUM+p];
		wire start = scl && scl_d && sda_d && !sda;
		wire stop = scl && scl_d && !sda_d && sda;
		wire rise = scl && !scl_d;
		wire fall = !scl && scl_d;
		wire hit = sh_reg[7:1] == addr_reg;
		wire [1:0] idx_inc = (idx_reg == IDX_TOP) ? idx_reg : idx_reg + 1'b1;
		wire [7:0] resp0 = resp_byte(cmd_reg, IDX_FIRST, temp_reg);
		wire [7:0] respn = resp_byte(cmd_reg, idx_reg, temp_reg);

		// Slave state machine; stop or an unset address sends it idle
		always_ff @(posedge i_clk) begin
			if (!i_rst_n || stop || !addr_ok_reg) begin
				st_reg <= ST_IDLE;
				sda_oe_reg[p] <= 1'b0;
				cnt_reg <= '0;
				sh_reg <= '0;
				tx_reg <= '0;
				cmd_reg <= '0;
				idx_reg <= '0;
				rw_reg <= 1'b0;
				nack_reg <= 1'b1;
			end else if (start) begin
				st_reg <= ST_ADDR;
				sda_oe_reg[p] <= 1'b0;
				cnt_reg <= '0;
			end else if (rise) begin
				if (st_reg == ST_ADDR || st_reg == ST_WDAT) begin
					sh_reg <= {sh_reg[6:0], sda};
					cnt_reg <= cnt_reg + 1'b1;
				end
				if (st_reg == ST_RACK) begin
					nack_reg <= sda;
				end
			end else if (fall) begin
				unique case (st_reg)
					ST_IDLE: begin
						sda_oe_reg[p] <= 1'b0;
					end
					ST_ADDR: begin
						if (cnt_reg == BIT_FULL) begin
							st_reg <= hit ? ST_AACK : ST_IDLE;
							sda_oe_reg[p] <= hit;
							rw_reg <= sh_reg[0];
						end
					end
					ST_AACK: begin
						cnt_reg <= '0;
						idx_reg <= rw_reg ? IDX_SECOND : IDX_FIRST;
						st_reg <= rw_reg ? ST_RDAT : ST_WDAT;
						tx_reg <= resp0;
						sda_oe_reg[p] <= rw_reg && !resp0[7];
					end
					ST_WDAT: begin
						if (cnt_reg == BIT_FULL) begin
							if (idx_reg == IDX_FIRST) begin
								cmd_reg <= sh_reg;
							end
							idx_reg <= idx_inc;
							st_reg <= ST_WACK;
							sda_oe_reg[p] <= 1'b1;
						end
					end
					ST_WACK: begin
						cnt_reg <= '0;
						st_reg <= ST_WDAT;
						sda_oe_reg[p] <= 1'b0;
					end
					ST_RDAT: begin
						if (cnt_reg == BIT_LAST) begin
							st_reg <= ST_RACK;
							sda_oe_reg[p] <= 1'b0;
						end else begin
							tx_reg <= {tx_reg[6:0], 1'b0};
							sda_oe_reg[p] <= !tx_reg[6];
							cnt_reg <= cnt_reg + 1'b1;
						end
					end
					ST_RACK: begin
						cnt_reg <= '0;
						st_reg <= nack_reg ? ST_IDLE : ST_RDAT;
						tx_reg <= respn;
						idx_reg <= idx_inc;
						sda_oe_reg[p] <= !nack_reg && !respn[7];
					end
					default: begin
						st_reg <= ST_IDLE;
						sda_oe_reg[p] <= 1'b0;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_sda = {PORT_NUM{lo_reg}};
	assign o_sda_oe = sda_oe_reg;
	assign o_startup_hold_n = lo_reg;
	assign o_startup_hold_n_oe = hold_oe_reg;
	assign o_fail_n = lo_reg;
	assign o_fail_n_oe = fail_oe_reg;
	assign o_rail = rail_reg;
	assign o_addr = addr_reg;
	assign o_ready = ready_reg;
endmodule : scp_top

// File: tb/scp_top_props.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module scp_top_props
	import scp_pkg::*;
#(
	parameter int LOCK_CYC = scp_pkg::LOCK_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Inputs watched
	input wire logic i_out_fault,
	input wire scp_pkg::scp_sw_t i_sw,
	// Outputs watched
	input wire logic [1:0] o_sda,
	input wire logic [1:0] o_sda_oe,
	input wire logic o_startup_hold_n,
	input wire logic o_startup_hold_n_oe,
	input wire logic o_fail_n,
	input wire logic o_fail_n_oe,
	input wire scp_pkg::scp_rail_t o_rail,
	input wire logic [6:0] o_addr,
	input wire logic o_ready
);
	logic [1:0] rail_prev_reg;
	int gap_reg;
	logic turn_on;
	// Any rail going from off to on
	assign turn_on = |(o_rail & ~rail_prev_reg);
	// Cycles since the last turn-on, saturating
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rail_prev_reg <= 2'h0;
			gap_reg <= LOCK_CYC;
		end else begin
			rail_prev_reg <= o_rail;
			gap_reg <= turn_on ? 1 : ((gap_reg < LOCK_CYC) ? gap_reg + 1 : gap_reg);
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Status pins and rails during start-up
	AST_HOLD_START: assert property (!o_ready |-> o_startup_hold_n_oe)
		else $error("hold pin released before ready");
	AST_HOLD_FREE: assert property ($rose(o_ready) |=> !o_startup_hold_n_oe [*3])
		else $error("hold pin not released after ready");
	AST_FAIL_FOLLOW: assert property (o_fail_n_oe == (!$past(o_ready) || $past(i_out_fault)))
		else $error("fail pin wrong");
	AST_OPEN_DRAIN: assert property (o_sda == 2'h0 && !o_startup_hold_n && !o_fail_n)
		else $error("open-drain level not low");
	AST_RAIL_HELD: assert property (!o_ready |-> o_rail == 2'h0)
		else $error("rail on before ready");
	// Address capture
	AST_READY_KEEP: assert property (o_ready |=> o_ready)
		else $error("ready dropped");
	AST_ADDR_KEEP: assert property (o_ready |-> $stable(o_addr))
		else $error("address moved after capture");
	AST_ADDR_FORM: assert property (o_addr[6:2] == 5'h08)
		else $error("address outside base range");
	// Rail control
	AST_SW_OFF: assert property ($past(i_sw.prio) && $past(o_ready) |->
		(o_rail & ~{$past(i_sw.main_on), $past(i_sw.aux_on)}) == 2'h0)
		else $error("rail on against software");
	AST_LOCKOUT: assert property (turn_on |-> gap_reg >= LOCK_CYC)
		else $error("turn-on inside lockout");
	cover property ($rose(o_ready));
	cover property (turn_on);
	cover property ($rose(o_sda_oe[1]));
	cover property ($rose(i_out_fault) && o_ready);
endmodule : scp_top_props

bind scp_top scp_top_props #(.LOCK_CYC(LOCK_CYC)) u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_out_fault(i_out_fault), .i_sw(i_sw), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
	.o_startup_hold_n(o_startup_hold_n), .o_startup_hold_n_oe(o_startup_hold_n_oe),
	.o_fail_n(o_fail_n), .o_fail_n_oe(o_fail_n_oe), .o_rail(o_rail), .o_addr(o_addr),
	.o_ready(o_ready));

// File: tb/scp_mgr_model.sv
`timescale 1ns/1ps
// ****
// Management bus master, one port
// ****
module scp_mgr_model (
	// Clock and device pull
	input wire logic i_clk,
	input wire logic i_dev_oe,
	// Bus lines with pull-ups
	output logic o_scl,
	output logic o_sda
);
	logic scl_reg = 1'b1;
	logic pull_reg = 1'b0;
	// Released lines float high through the pull-ups
	assign o_scl = scl_reg;
	assign o_sda = !(pull_reg || i_dev_oe);
	task automatic ph();
		repeat (10) @(posedge i_clk);
	endtask : ph
	task automatic clk_bit(input logic b, output logic s);
		scl_reg <= 1'b0;
		ph();
		pull_reg <= !b;
		ph();
		scl_reg <= 1'b1;
		ph();
		s = o_sda;
	endtask : clk_bit
	task automatic start();
		scl_reg <= 1'b0;
		ph();
		pull_reg <= 1'b0;
		ph();
		scl_reg <= 1'b1;
		ph();
		pull_reg <= 1'b1;
		ph();
	endtask : start
	task automatic stop();
		scl_reg <= 1'b0;
		ph();
		pull_reg <= 1'b1;
		ph();
		scl_reg <= 1'b1;
		ph();
		pull_reg <= 1'b0;
		ph();
	endtask : stop
	task automatic put_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
		clk_bit(1'b1, s);
		ack = !s;
	endtask : put_byte
	// Write the command, then read n bytes; the last one is refused
	task automatic xfer(input logic [6:0] a, input logic [7:0] cmd, input int n,
		output logic [15:0] d, output logic ack);
		logic s;
		logic [7:0] b;
		d = 16'h0000;
		@(posedge i_clk);
		start();
		put_byte({a, 1'b0}, ack);
		if (ack) begin
			put_byte(cmd, s);
			ack &= s;
			start();
			put_byte({a, 1'b1}, s);
			ack &= s;
			for (int i = 0; i < n; i++) begin
				for (int j = 7; j >= 0; j--) clk_bit(1'b1, b[j]);
				clk_bit(i == n - 1, s);
				d = {d[7:0], b};
			end
		end
		stop();
	endtask : xfer
endmodule : scp_mgr_model

// File: tb/supply_control_pins_bench.sv
`timescale 1ns/1ps
module supply_control_pins_bench;
	import scp_pkg::*;
	localparam int DEB = 8;
	localparam int LOCK = 16;
	localparam int ADR = 32;
	localparam int LIMIT = 30000;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic en_n = 1'b1, inh_n = 1'b1, sb0_n = 1'b1, sb1_n = 1'b1, ok = 1'b0, flt = 1'b0;
	logic [7:0] ta = 8'h00, tb = 8'h00;
	scp_sw_t sw = 3'h0;
	wire [1:0] scl, sda;
	logic [1:0] sda_o, sda_oe;
	logic hold_n, hold_oe, fail_n, fail_oe, ready;
	scp_rail_t rail;
	logic [6:0] addr;
	int errors = 0, check_count = 0, cyc = 0;
	logic [31:0] seed = 32'h000081cc;
	// ****
	// Design and bus masters
	// ****
	scp_top #(.DEB_CYC(DEB), .LOCK_CYC(LOCK), .ADDR_CYC(ADR)) dut (.i_clk(i_clk),
		.i_rst_n(i_rst_n), .i_enable_n(en_n), .i_inhibit_n(inh_n), .i_slot_bit0_n(sb0_n),
		.i_slot_bit1_n(sb1_n), .i_supply_ok(ok), .i_out_fault(flt), .i_temp_a(ta),
		.i_temp_b(tb), .i_sw(sw), .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe),
		.o_startup_hold_n(hold_n), .o_startup_hold_n_oe(hold_oe), .o_fail_n(fail_n),
		.o_fail_n_oe(fail_oe), .o_rail(rail), .o_addr(addr), .o_ready(ready));
	scp_mgr_model mgr0 (.i_clk(i_clk), .i_dev_oe(sda_oe[0] & ~sda_o[0]), .o_scl(scl[0]),
		.o_sda(sda[0]));
	scp_mgr_model mgr1 (.i_clk(i_clk), .i_dev_oe(sda_oe[1] & ~sda_o[1]), .o_scl(scl[1]),
		.o_sda(sda[1]));
	// Clock
	always #5 i_clk = ~i_clk;
	// ****
	// Helpers
	// ****
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [7:0] hotter(input logic [7:0] a, input logic [7:0] b);
		return ($signed(a) > $signed(b)) ? a : b;
	endfunction : hotter
	function automatic logic [1:0] exp_rail(input logic en, input logic inh);
		return en ? 2'h0 : (inh ? 2'h3 : 2'h1);
	endfunction : exp_rail
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : wait_cyc
	task automatic power_up(input logic [1:0] slot_n, input logic sup);
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		{sb1_n, sb0_n} <= slot_n;
		ok <= sup;
		en_n <= 1'b1;
		wait_cyc(8);
		i_rst_n <= 1'b1;
		wait_cyc(ADR + 4);
	endtask : power_up
	task automatic bus(input int p, input logic [6:0] a, input logic [7:0] c, input int n,
		output logic [15:0] d, output logic ack);
		if (p == 0) mgr0.xfer(a, c, n, d, ack);
		else mgr1.xfer(a, c, n, d, ack);
	endtask : bus
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : tally_and_finish
	// Hang guard
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			errors++;
			$display("ERROR cycle limit expected %0d seen %0d", LIMIT - 1, cyc);
			tally_and_finish();
		end
	end
	// ****
	// Scenarios
	// ****
	initial begin : main
		logic [15:0] d;
		logic ack;
		logic [7:0] x;
		logic [6:0] a;
		int n;
		for (int k = 0; k < 4; k++) begin
			power_up(~2'(k), k != 0);
			a = 7'h20 + 7'(k);
			if (k == 0) begin
				en_n <= 1'b0;
				wait_cyc(20);
				#1;
				check("start-up pins", 16'({ready, hold_oe, fail_oe, rail}), 16'h000c);
				@(posedge i_clk);
				ok <= 1'b1;
				en_n <= 1'b1;
				wait_cyc(3);
				#1;
				check("ready pins", 16'({ready, hold_oe, fail_oe}), 16'h0004);
			end
			check("address", 16'(addr), 16'(a));
			@(posedge i_clk);
			x = 8'(rnd());
			ta <= (k == 0) ? 8'h80 : x;
			tb <= (k == 0) ? 8'h7f : ((k == 1) ? x : 8'(rnd()));
			{sb1_n, sb0_n} <= 2'(k);
			bus(k % 2, a, CMD_HOT, 1, d, ack);
			check("ack", 16'(ack), 16'h0001);
			check("hot temp", d, 16'(hotter(ta, tb)));
			bus(k % 2, a, CMD_BOTH, 2, d, ack);
			check("both temps", d, {ta, tb});
			bus(k % 2, a, CMD_HOT ^ 8'(k + 1), 1, d, ack);
			check("unknown command", d, 16'(FILL_BYTE));
			bus(k % 2, a ^ 7'h01, CMD_HOT, 1, d, ack);
			check("foreign ack", 16'(ack), 16'h0000);
			#1;
			check("address held", 16'(addr), 16'(a));
		end
		for (int j = 0; j < 4; j++) begin
			@(posedge i_clk);
			en_n <= j[1];
			inh_n <= j[0];
			wait_cyc(40);
			#1;
			check("rails", 16'(rail), 16'(exp_rail(j[1], j[0])));
		end
		@(posedge i_clk);
		en_n <= 1'b0;
		wait_cyc(DEB / 2);
		en_n <= 1'b1;
		wait_cyc(30);
		#1;
		check("glitch", 16'(rail), 16'h0000);
		@(posedge i_clk);
		en_n <= 1'b0;
		inh_n <= 1'b0;
		n = 0;
		while (rail.aux_on !== 1'b1 && n < 100) begin
			@(posedge i_clk);
			n++;
		end
		inh_n <= 1'b1;
		wait_cyc(12);
		#1;
		check("lockout", 16'(rail), 16'h0001);
		wait_cyc(30);
		#1;
		check("after lockout", 16'(rail), 16'h0003);
		@(posedge i_clk);
		sw <= 3'h4;
		wait_cyc(3);
		#1;
		check("software off", 16'(rail), 16'h0000);
		@(posedge i_clk);
		sw <= 3'h5;
		wait_cyc(3);
		#1;
		check("software aux", 16'(rail), 16'h0001);
		@(posedge i_clk);
		sw <= 3'h0;
		flt <= 1'b1;
		wait_cyc(2);
		#1;
		check("fault pin", 16'(fail_oe), 16'h0001);
		@(posedge i_clk);
		flt <= 1'b0;
		wait_cyc(30);
		#1;
		check("pins regain", 16'({fail_oe, rail}), 16'h0003);
		tally_and_finish();
	end
endmodule : supply_control_pins_bench
